// file: core/stsrq_status_srq.sv
// Status bytes, serial poll byte and service request of the instrument
// Notes on behaviour
// - Each status bit reads 1 while its event happened or condition holds.
// - Poll bit 0 means no scan running (pause counts running); bit 1 idle.
// - Poll bit 4 shows a non-empty output buffer; bit 7 always reads zero.
// - Poll bits 2, 3, 5 are OR of their byte ANDed with its mask.
// - Summary stays set until all enabled source bits are cleared.
// - A poll-byte query changes nothing; each bit tracks its condition.
// - Queried bit 6 is 1 whenever any enabled poll bit is set.
// - A serial poll clears nothing but the request bit.
// - First poll after a request returns bit 6 set and withdraws it.
// - A request rises only on a 0-to-1 change of an enabled bit.
// - Several bits in one byte give one request through the summary.
// - Event bits 0 and 2 mark queue overflows; overflows flush the queues.
// - Event bit 4 marks failed command or bad parameter; bit 5 illegal.
// - Event bit 6 marks key or knob, bit 7 power-on; bits 1, 3 unused.
// - Event, measurement and fault bits stick until read or cleared.
// - Measurement bits 0..3: input, filter, output overload, reference unlock.
// - Measurement bit 4 marks a detection range switch at 199.21/203.12 Hz.
// - Bit 5 marks indirect time-constant change; bit 6 external-mode trigger.
// - Fault bits 1, 2, 4: backup failure, RAM error, ROM error.
// - Fault bits 5, 6, 7: fast transfer abort, processor test, math error.
// - Whole-byte read clears the byte; single-bit read clears that bit.
// - Clear-status clears all status bytes and keeps every enable mask.
module stsrq_status_srq (
	// Clock and reset
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_i,
	// Query port
	input  wire logic                    query_valid_i,
	input  wire stsrq_pkg::stsrq_target_t query_sel_i,
	input  wire logic                    query_bit_mode_i,
	input  wire logic [2:0]              query_bit_idx_i,
	output logic [7:0]                   query_data_o,
	output logic                         query_done_o,
	// Enable mask write port
	input  wire logic                    write_valid_i,
	input  wire stsrq_pkg::stsrq_target_t write_sel_i,
	input  wire logic                    write_bit_mode_i,
	input  wire logic [2:0]              write_bit_idx_i,
	input  wire logic [7:0]              write_data_i,
	// Clear-status command
	input  wire logic                    clear_status_i,
	// Serial poll and service request
	input  wire logic                    serial_poll_i,
	output logic [7:0]                   spoll_data_o,
	output logic                         spoll_done_o,
	output logic                         srq_o,
	// Live conditions
	input  wire logic                    scan_idle_i,
	input  wire logic                    command_idle_i,
	input  wire logic                    out_buffer_nonempty_i,
	// Command and front-panel events
	input  wire logic                    rx_queue_overflow_i,
	input  wire logic                    tx_queue_overflow_i,
	input  wire logic                    command_failed_i,
	input  wire logic                    illegal_command_i,
	input  wire logic                    user_activity_i,
	output logic                         queue_flush_o,
	// Measurement events
	input  wire logic                    overload_input_i,
	input  wire logic                    overload_filter_i,
	input  wire logic                    overload_output_i,
	input  wire logic                    ref_unlocked_i,
	input  wire logic [31:0]             detect_freq_chz_i,
	input  wire logic                    indirect_tau_change_i,
	input  wire logic                    storage_trigger_i,
	input  wire logic                    ext_trigger_mode_i,
	output logic                         upper_range_o,
	// Fault events
	input  wire logic                    backup_fail_i,
	input  wire logic                    ram_fail_i,
	input  wire logic                    rom_fail_i,
	input  wire logic                    fast_abort_i,
	input  wire logic                    dsp_fail_i,
	input  wire logic                    math_error_i
);

	typedef struct packed {
		logic [7:0] sp_enable;
		logic [7:0] prev_enabled;
		logic       pending;
		logic       upper_range;
		logic [7:0] query_data;
		logic       query_done;
		logic [7:0] spoll_data;
		logic       spoll_done;
		logic       queue_flush;
	} stsrq_state_t;

	stsrq_state_t q;
	stsrq_state_t next_q;

	stsrq_byte_if std_if ();
	stsrq_byte_if meas_if ();
	stsrq_byte_if fault_if ();

	logic [7:0] sp_live;
	logic [7:0] sp_enabled;
	logic [7:0] sp_rise;
	logic [7:0] stb_byte;
	logic       range_ev;

	// Whole byte or a single bit selected by index
	function automatic logic [7:0] sel_mask(input logic bit_mode,
		input logic [2:0] idx);
		logic [7:0] m;
		m = 8'hFF;
		if (bit_mode)
		begin
			m = 8'h01 << idx;
		end
		return m;
	endfunction : sel_mask

	// Value returned by a query of a whole byte or of one bit
	function automatic logic [7:0] bit_pick(input logic [7:0] src,
		input logic bit_mode, input logic [2:0] idx);
		logic [7:0] v;
		v = src;
		if (bit_mode)
		begin
			v = {7'h00, src[idx]};
		end
		return v;
	endfunction : bit_pick

	stsrq_status_byte #(
		.VALID (stsrq_pkg::STD_VALID),
		.RESET (stsrq_pkg::STD_RESET)
	) u_std (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.bus       (std_if)
	);

	stsrq_status_byte #(
		.VALID (stsrq_pkg::MEAS_VALID),
		.RESET (stsrq_pkg::MEAS_RESET)
	) u_meas (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.bus       (meas_if)
	);

	stsrq_status_byte #(
		.VALID (stsrq_pkg::FAULT_VALID),
		.RESET (stsrq_pkg::FAULT_RESET)
	) u_fault (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.bus       (fault_if)
	);

	// Serial poll byte built from live conditions and summaries
	always_comb
	begin
		sp_live = 8'h00;
		sp_live[stsrq_pkg::SP_SCAN_IDLE] = scan_idle_i;
		sp_live[stsrq_pkg::SP_CMD_IDLE]  = command_idle_i;
		sp_live[stsrq_pkg::SP_FAULT_SUM] = fault_if.summary;
		sp_live[stsrq_pkg::SP_MEAS_SUM]  = meas_if.summary;
		sp_live[stsrq_pkg::SP_OUT_AVAIL] = out_buffer_nonempty_i;
		sp_live[stsrq_pkg::SP_EVENT_SUM] = std_if.summary;
		sp_enabled = sp_live & q.sp_enable & stsrq_pkg::SP_REQ_MASK;
		sp_rise    = sp_enabled & ~q.prev_enabled;
		stb_byte   = sp_live;
		stb_byte[stsrq_pkg::SP_SRQ] = |sp_enabled;
	end

	// Detection range with hysteresis between the two limits
	always_comb
	begin
		range_ev = 1'b0;
		if (!q.upper_range && detect_freq_chz_i > stsrq_pkg::RANGE_HIGH_CHZ)
		begin
			range_ev = 1'b1;
		end
		else if (q.upper_range && detect_freq_chz_i < stsrq_pkg::RANGE_LOW_CHZ)
		begin
			range_ev = 1'b1;
		end
	end

	// Events into the sticky bytes
	always_comb
	begin
		std_if.set_ev = 8'h00;
		std_if.set_ev[stsrq_pkg::EV_RX_OVF]   = rx_queue_overflow_i;
		std_if.set_ev[stsrq_pkg::EV_TX_OVF]   = tx_queue_overflow_i;
		std_if.set_ev[stsrq_pkg::EV_CMD_FAIL] = command_failed_i;
		std_if.set_ev[stsrq_pkg::EV_ILLEGAL]  = illegal_command_i;
		std_if.set_ev[stsrq_pkg::EV_USER]     = user_activity_i;

		meas_if.set_ev = 8'h00;
		meas_if.set_ev[stsrq_pkg::MS_OVL_INPUT]  = overload_input_i;
		meas_if.set_ev[stsrq_pkg::MS_OVL_FILTER] = overload_filter_i;
		meas_if.set_ev[stsrq_pkg::MS_OVL_OUTPUT] = overload_output_i;
		meas_if.set_ev[stsrq_pkg::MS_UNLOCK]     = ref_unlocked_i;
		meas_if.set_ev[stsrq_pkg::MS_RANGE]      = range_ev;
		meas_if.set_ev[stsrq_pkg::MS_TAU]        = indirect_tau_change_i;
		meas_if.set_ev[stsrq_pkg::MS_TRIG]       =
			storage_trigger_i & ext_trigger_mode_i;

		fault_if.set_ev = 8'h00;
		fault_if.set_ev[stsrq_pkg::FT_BACKUP]     = backup_fail_i;
		fault_if.set_ev[stsrq_pkg::FT_RAM]        = ram_fail_i;
		fault_if.set_ev[stsrq_pkg::FT_ROM]        = rom_fail_i;
		fault_if.set_ev[stsrq_pkg::FT_FAST_ABORT] = fast_abort_i;
		fault_if.set_ev[stsrq_pkg::FT_DSP]        = dsp_fail_i;
		fault_if.set_ev[stsrq_pkg::FT_MATH]       = math_error_i;
	end

	// Clears by query and by clear-status, and enable mask writes
	always_comb
	begin
		logic [7:0] rd_mask;
		logic [7:0] wr_mask;
		logic [7:0] wr_data;
		rd_mask = sel_mask(query_bit_mode_i, query_bit_idx_i);
		wr_mask = sel_mask(write_bit_mode_i, write_bit_idx_i);
		wr_data = write_bit_mode_i ? {8{write_data_i[0]}} : write_data_i;

		std_if.clr_mask   = clear_status_i ? 8'hFF : 8'h00;
		meas_if.clr_mask  = clear_status_i ? 8'hFF : 8'h00;
		fault_if.clr_mask = clear_status_i ? 8'hFF : 8'h00;
		if (query_valid_i)
		begin
			case (query_sel_i)
				stsrq_pkg::TGT_STD:   std_if.clr_mask   |= rd_mask;
				stsrq_pkg::TGT_MEAS:  meas_if.clr_mask  |= rd_mask;
				stsrq_pkg::TGT_FAULT: fault_if.clr_mask |= rd_mask;
				default:              ;
			endcase
		end

		std_if.en_we     = 8'h00;
		meas_if.en_we    = 8'h00;
		fault_if.en_we   = 8'h00;
		std_if.en_wdata  = wr_data;
		meas_if.en_wdata = wr_data;
		fault_if.en_wdata = wr_data;
		if (write_valid_i)
		begin
			case (write_sel_i)
				stsrq_pkg::TGT_STD_EN:   std_if.en_we   = wr_mask;
				stsrq_pkg::TGT_MEAS_EN:  meas_if.en_we  = wr_mask;
				stsrq_pkg::TGT_FAULT_EN: fault_if.en_we = wr_mask;
				default:                 ;
			endcase
		end
	end

	// Next state of the controller
	always_comb
	begin
		logic [7:0] src;
		logic [7:0] wr_mask;
		logic [7:0] wr_data;
		src     = 8'h00;
		next_q  = q;
		wr_mask = sel_mask(write_bit_mode_i, write_bit_idx_i);
		wr_data = write_bit_mode_i ? {8{write_data_i[0]}} : write_data_i;

		if (write_valid_i && write_sel_i == stsrq_pkg::TGT_SP_EN)
		begin
			next_q.sp_enable = (q.sp_enable & ~wr_mask) | (wr_data & wr_mask);
		end

		if (range_ev)
		begin
			next_q.upper_range = ~q.upper_range;
		end

		// A new rise wins over the withdrawal by a poll
		next_q.prev_enabled = sp_enabled;
		next_q.pending = (|sp_rise) |
			(q.pending & ~serial_poll_i & ~clear_status_i);

		// Poll returns the live byte with the latched request
		next_q.spoll_done = serial_poll_i;
		if (serial_poll_i)
		begin
			next_q.spoll_data = sp_live;
			next_q.spoll_data[stsrq_pkg::SP_SRQ] = q.pending;
		end

		case (query_sel_i)
			stsrq_pkg::TGT_SPOLL:    src = stb_byte;
			stsrq_pkg::TGT_STD:      src = std_if.status;
			stsrq_pkg::TGT_MEAS:     src = meas_if.status;
			stsrq_pkg::TGT_FAULT:    src = fault_if.status;
			stsrq_pkg::TGT_SP_EN:    src = q.sp_enable;
			stsrq_pkg::TGT_STD_EN:   src = std_if.enable;
			stsrq_pkg::TGT_MEAS_EN:  src = meas_if.enable;
			stsrq_pkg::TGT_FAULT_EN: src = fault_if.enable;
			default:                 src = 8'h00;
		endcase
		next_q.query_done = query_valid_i;
		if (query_valid_i)
		begin
			next_q.query_data = bit_pick(src, query_bit_mode_i, query_bit_idx_i);
		end

		next_q.queue_flush = rx_queue_overflow_i | tx_queue_overflow_i;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			q.sp_enable    <= stsrq_pkg::ENABLE_RESET;
			q.prev_enabled <= 8'h00;
			q.pending      <= 1'b0;
			q.upper_range  <= 1'b0;
			q.query_data   <= 8'h00;
			q.query_done   <= 1'b0;
			q.spoll_data   <= 8'h00;
			q.spoll_done   <= 1'b0;
			q.queue_flush  <= 1'b0;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign query_data_o  = q.query_data;
	assign query_done_o  = q.query_done;
	assign spoll_data_o  = q.spoll_data;
	assign spoll_done_o  = q.spoll_done;
	assign srq_o         = q.pending;
	assign queue_flush_o = q.queue_flush;
	assign upper_range_o = q.upper_range;

	a_rise_requests: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(sp_rise != 8'h00) |=> srq_o
	) else $error("enabled rise gave no service request");

	a_no_spurious_srq: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(!srq_o && sp_rise == 8'h00) |=> !srq_o
	) else $error("service request without an enabled rise");

	a_poll_bit6: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		serial_poll_i |=> (spoll_done_o && spoll_data_o[6] == $past(srq_o))
	) else $error("poll bit 6 does not show the pending request");

	a_poll_withdraws: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(serial_poll_i && sp_rise == 8'h00) |=> !srq_o
	) else $error("poll did not withdraw the request");

	a_stb_bit6: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(query_valid_i && query_sel_i == stsrq_pkg::TGT_SPOLL && !query_bit_mode_i)
			|=> (query_data_o[6] == |($past(sp_live) & $past(q.sp_enable)
				& stsrq_pkg::SP_REQ_MASK))
	) else $error("queried bit 6 does not track enabled bits");

	a_scan_bit: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(query_valid_i && query_sel_i == stsrq_pkg::TGT_SPOLL && !query_bit_mode_i)
			|=> (query_data_o[0] == $past(scan_idle_i) && !query_data_o[7])
	) else $error("queried poll byte bit 0 or 7 wrong");

	a_flush_queues: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(rx_queue_overflow_i || tx_queue_overflow_i) |=> queue_flush_o
	) else $error("overflow did not flush the queues");

endmodule : stsrq_status_srq

// file: core/stsrq_pkg.sv
// Constants, field positions and types of the status and service-request block
package stsrq_pkg;

	localparam int BYTE_W = 8;

	// Serial poll byte fields
	localparam int SP_SCAN_IDLE = 0;
	localparam int SP_CMD_IDLE  = 1;
	localparam int SP_FAULT_SUM = 2;
	localparam int SP_MEAS_SUM  = 3;
	localparam int SP_OUT_AVAIL = 4;
	localparam int SP_EVENT_SUM = 5;
	localparam int SP_SRQ       = 6;

	// Standard event byte fields
	localparam int EV_RX_OVF   = 0;
	localparam int EV_TX_OVF   = 2;
	localparam int EV_CMD_FAIL = 4;
	localparam int EV_ILLEGAL  = 5;
	localparam int EV_USER     = 6;
	localparam int EV_POWER_ON = 7;

	// Measurement byte fields
	localparam int MS_OVL_INPUT  = 0;
	localparam int MS_OVL_FILTER = 1;
	localparam int MS_OVL_OUTPUT = 2;
	localparam int MS_UNLOCK     = 3;
	localparam int MS_RANGE      = 4;
	localparam int MS_TAU        = 5;
	localparam int MS_TRIG       = 6;

	// Fault byte fields
	localparam int FT_BACKUP     = 1;
	localparam int FT_RAM        = 2;
	localparam int FT_ROM        = 4;
	localparam int FT_FAST_ABORT = 5;
	localparam int FT_DSP        = 6;
	localparam int FT_MATH       = 7;

	// Implemented bits, the others read zero; poll bits that can raise a request
	localparam logic [7:0] STD_VALID    = 8'hF5;
	localparam logic [7:0] MEAS_VALID   = 8'h7F;
	localparam logic [7:0] FAULT_VALID  = 8'hF6;
	localparam logic [7:0] SP_REQ_MASK  = 8'h3F;

	// Reset values; power-on shows in the standard event byte
	localparam logic [7:0] STD_RESET    = 8'h80;
	localparam logic [7:0] MEAS_RESET   = 8'h00;
	localparam logic [7:0] FAULT_RESET  = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;

	// Detection range limits in units of 0.01 Hz (199.21 Hz, 203.12 Hz)
	localparam logic [31:0] RANGE_LOW_CHZ  = 32'h0000_4DD1;
	localparam logic [31:0] RANGE_HIGH_CHZ = 32'h0000_4F58;

	typedef enum logic [2:0] {
		TGT_SPOLL,
		TGT_STD,
		TGT_MEAS,
		TGT_FAULT,
		TGT_SP_EN,
		TGT_STD_EN,
		TGT_MEAS_EN,
		TGT_FAULT_EN
	} stsrq_target_t;

endpackage : stsrq_pkg

// file: core/stsrq_byte_if.sv
// Link between the controller and one sticky status byte
interface stsrq_byte_if;
	logic [7:0] set_ev;
	logic [7:0] clr_mask;
	logic [7:0] en_we;
	logic [7:0] en_wdata;
	logic [7:0] status;
	logic [7:0] enable;
	logic       summary;

	modport ctrl (
		output set_ev, clr_mask, en_we, en_wdata,
		input  status, enable, summary
	);
	modport store (
		input  set_ev, clr_mask, en_we, en_wdata,
		output status, enable, summary
	);
endinterface : stsrq_byte_if

// file: core/stsrq_status_byte.sv
// One sticky status byte with its enable mask and summary bit
module stsrq_status_byte #(
	parameter logic [7:0] VALID = 8'hFF,
	parameter logic [7:0] RESET = 8'h00
) (
	// Clock and reset
	input  wire logic    ref_clk_i,
	input  wire logic    rst_i,
	// Controller side
	stsrq_byte_if.store  bus
);

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] enable;
	} stsrq_byte_state_t;

	stsrq_byte_state_t q;
	stsrq_byte_state_t next_q;

	always_comb
	begin
		next_q = q;
		// A new event wins over a clear in the same cycle
		next_q.status = ((q.status & ~bus.clr_mask) | bus.set_ev) & VALID;
		next_q.enable = (q.enable & ~bus.en_we) | (bus.en_wdata & bus.en_we);
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			q.status <= RESET;
			q.enable <= stsrq_pkg::ENABLE_RESET;
		end
		else
		begin
			q <= next_q;
		end
	end

	assign bus.status  = q.status;
	assign bus.enable  = q.enable;
	assign bus.summary = |(q.status & q.enable);

	a_sticky_hold: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(bus.clr_mask == 8'h00) |=> ((q.status & $past(q.status)) == $past(q.status))
	) else $error("status bit dropped without a clear");

	a_event_wins: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(bus.set_ev != 8'h00) |=>
			((q.status & $past(bus.set_ev) & VALID) ==
				($past(bus.set_ev) & VALID))
	) else $error("event did not set its status bit");

	a_read_clears: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(bus.set_ev == 8'h00 && bus.clr_mask != 8'h00) |=>
			((q.status & $past(bus.clr_mask)) == 8'h00)
	) else $error("read did not clear the addressed bits");

	a_mask_kept: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(bus.en_we == 8'h00) |=> (q.enable == $past(q.enable))
	) else $error("enable mask changed without a write");

endmodule : stsrq_status_byte

// file: dv/stsrq_gpib_host.sv
// Bus controller model that answers service requests with serial polls
module stsrq_gpib_host (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Device side
	input  wire logic       srq_i,
	input  wire logic [7:0] spoll_data_i,
	output logic            serial_poll_o,
	// Bench side
	input  wire logic       auto_en_i,
	input  wire logic       poll_req_i,
	input  wire logic [3:0] dly_i,
	output logic [7:0]      last_poll_o,
	output int              polls_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		serial_poll_o = 1'b0;
		last_poll_o = 8'h00;
		polls_o = 0;
		forever
		begin
			@(negedge ref_clk_i);
			if (!rst_i && ((auto_en_i && srq_i) || poll_req_i))
			begin
				repeat (dly_i) @(negedge ref_clk_i);
				serial_poll_o = 1'b1;
				@(negedge ref_clk_i);
				serial_poll_o = 1'b0;
				last_poll_o = spoll_data_i;
				polls_o = polls_o + 1;
			end
		end
	end
endmodule : stsrq_gpib_host

// file: dv/status_reporting_srq_tb.sv
// Self-checking bench of the status and service-request block
module status_reporting_srq_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk_i, rst_i, q_v, q_bm, w_v, w_bm, clr, spoll, ext;
	logic scan, cmd, obuf, q_done, srq, flush, upper, auto_en, poll_req;
	logic sp_done, poll_seen;
	stsrq_pkg::stsrq_target_t q_sel, w_sel;
	logic [2:0]  q_idx, w_idx;
	logic [7:0]  w_d, q_d, sp_d, last_poll, r;
	logic [16:0] ev;
	logic [31:0] freq;
	logic [3:0]  dly;
	logic [7:0]  exp_st [4];
	logic [7:0]  mask [4];
	int          bad_count, num_checks, polls, cyc, t, n0;

	stsrq_status_srq dut_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.query_valid_i(q_v), .query_sel_i(q_sel), .query_bit_mode_i(q_bm),
		.query_bit_idx_i(q_idx), .query_data_o(q_d), .query_done_o(q_done),
		.write_valid_i(w_v), .write_sel_i(w_sel), .write_bit_mode_i(w_bm),
		.write_bit_idx_i(w_idx), .write_data_i(w_d), .clear_status_i(clr),
		.serial_poll_i(spoll), .spoll_data_o(sp_d), .spoll_done_o(sp_done),
		.srq_o(srq), .scan_idle_i(scan), .command_idle_i(cmd),
		.out_buffer_nonempty_i(obuf), .rx_queue_overflow_i(ev[0]),
		.tx_queue_overflow_i(ev[1]), .command_failed_i(ev[2]),
		.illegal_command_i(ev[3]), .user_activity_i(ev[4]),
		.queue_flush_o(flush), .overload_input_i(ev[5]),
		.overload_filter_i(ev[6]), .overload_output_i(ev[7]),
		.ref_unlocked_i(ev[8]), .detect_freq_chz_i(freq),
		.indirect_tau_change_i(ev[9]), .storage_trigger_i(ev[10]),
		.ext_trigger_mode_i(ext), .upper_range_o(upper),
		.backup_fail_i(ev[11]), .ram_fail_i(ev[12]), .rom_fail_i(ev[13]),
		.fast_abort_i(ev[14]), .dsp_fail_i(ev[15]), .math_error_i(ev[16])
	);

	stsrq_gpib_host host_u (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .srq_i(srq),
		.spoll_data_i(sp_d), .serial_poll_o(spoll), .auto_en_i(auto_en),
		.poll_req_i(poll_req), .dly_i(dly), .last_poll_o(last_poll),
		.polls_o(polls)
	);

	initial
	begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end

	// Event inputs mapped to {fault, measurement, standard event}
	function automatic logic [23:0] map_ev(input logic [16:0] e, input logic x);
		return {e[16:14], e[13], 1'b0, e[12], e[11], 1'b0,
			1'b0, e[10] & x, e[9], 1'b0, e[8:5],
			1'b0, e[4], e[3], e[2], 1'b0, e[1], 1'b0, e[0]};
	endfunction : map_ev

	function automatic logic [7:0] exp_spoll();
		logic [7:0] p;
		p = {2'b00, |(exp_st[1] & mask[1]), obuf, |(exp_st[2] & mask[2]),
			|(exp_st[3] & mask[3]), cmd, scan};
		p[6] = |(p[5:0] & mask[0][5:0]);
		return p;
	endfunction : exp_spoll

	task automatic check_byte(input string n, input logic [7:0] x,
		input logic [7:0] g);
		num_checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, x, g);
		end
	endtask : check_byte

	task automatic check_bit(input string n, input logic x, input logic g);
		num_checks++;
		if (g !== x)
		begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", n, x, g);
		end
	endtask : check_bit

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic query(input stsrq_pkg::stsrq_target_t s, input logic bm,
		input logic [2:0] i, output logic [7:0] d);
		@(negedge ref_clk_i);
		q_v = 1'b1;
		q_sel = s;
		q_bm = bm;
		q_idx = i;
		@(negedge ref_clk_i);
		q_v = 1'b0;
		check_bit("query_done", 1'b1, q_done);
		d = q_d;
	endtask : query

	task automatic wr(input stsrq_pkg::stsrq_target_t s, input logic bm,
		input logic [2:0] i, input logic [7:0] d);
		@(negedge ref_clk_i);
		w_v = 1'b1;
		w_sel = s;
		w_bm = bm;
		w_idx = i;
		w_d = d;
		@(negedge ref_clk_i);
		w_v = 1'b0;
		if (s >= stsrq_pkg::TGT_SP_EN)
		begin
			if (bm)
				mask[int'(s) - 4][i] = d[0];
			else
				mask[int'(s) - 4] = d;
		end
	endtask : wr

	task automatic pulse(input logic [16:0] e);
		logic [23:0] m;
		m = map_ev(e, ext);
		@(negedge ref_clk_i);
		ev = e;
		@(negedge ref_clk_i);
		ev = 17'h0_0000;
		check_bit("queue_flush", e[0] | e[1], flush);
		for (int k = 1; k < 4; k++)
			exp_st[k] |= m[8 * k - 8 +: 8];
	endtask : pulse

	task automatic clear_st();
		@(negedge ref_clk_i);
		clr = 1'b1;
		@(negedge ref_clk_i);
		clr = 1'b0;
		exp_st = '{default: 8'h00};
	endtask : clear_st

	task automatic wait_polls(input int n);
		for (int k = 0; k < 50 && polls < n; k++)
			@(negedge ref_clk_i);
	endtask : wait_polls

	// Cut a hang short well past the expected run of about 420 cycles
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	// Poll acknowledge follows each sampled poll by one cycle
	always @(posedge ref_clk_i)
		poll_seen <= spoll;

	always @(negedge ref_clk_i)
	begin
		if (!rst_i)
			check_bit("spoll_done", poll_seen, sp_done);
	end

	initial
	begin
		{rst_i, q_v, q_bm, w_v, w_bm, clr, ext} = 7'h7F & 7'h40;
		{scan, cmd, obuf, auto_en, poll_req} = 5'h00;
		{q_idx, w_idx, w_d, ev, dly} = '0;
		q_sel = stsrq_pkg::TGT_SPOLL;
		w_sel = stsrq_pkg::TGT_SPOLL;
		freq = 32'h0000_4E20;
		exp_st = '{8'h00, 8'h80, 8'h00, 8'h00};
		mask = '{default: 8'h00};
		void'($urandom(80625));
		repeat (12) @(negedge ref_clk_i);
		rst_i = 1'b0;

		query(stsrq_pkg::TGT_STD, 1'b1, 3'd7, r);
		check_byte("power_on_bit", 8'h01, r);
		for (int k = 0; k < 8; k++)
		begin
			query(stsrq_pkg::stsrq_target_t'(k), 1'b0, 3'd0, r);
			check_byte("reset_value", 8'h00, r);
		end
		exp_st[1] = 8'h00;
		$display("test reset done");

		wr(stsrq_pkg::TGT_MEAS, 1'b0, 3'd0, 8'hFF);
		for (int k = 0; k < 4; k++)
		begin
			wr(stsrq_pkg::stsrq_target_t'(k + 4), 1'b0, 3'd0, 8'($urandom));
			query(stsrq_pkg::stsrq_target_t'(k + 4), 1'b0, 3'd0, r);
			check_byte("mask_readback", mask[k], r);
		end
		$display("test masks done");

		for (int i = 0; i < 40; i++)
		begin
			{scan, cmd, obuf, ext} = 4'($urandom);
			pulse(17'($urandom & $urandom & $urandom));
			@(negedge ref_clk_i);
			query(stsrq_pkg::TGT_SPOLL, 1'b0, 3'd0, r);
			check_byte("spoll_query", exp_spoll(), r);
			t = 1 + $urandom % 3;
			query(stsrq_pkg::stsrq_target_t'(t), 1'b0, 3'd0, r);
			check_byte("status_byte", exp_st[t], r);
			exp_st[t] = 8'h00;
		end
		$display("test random done");

		for (int k = 0; k < 4; k++)
		begin
			@(negedge ref_clk_i);
			freq = (k < 2) ? stsrq_pkg::RANGE_HIGH_CHZ + k
				: stsrq_pkg::RANGE_LOW_CHZ - (k - 2);
			repeat (3) @(negedge ref_clk_i);
			check_bit("upper_range", (k == 1) || (k == 2), upper);
			query(stsrq_pkg::TGT_MEAS, 1'b1, 3'd4, r);
			check_byte("range_bit", {7'h00, k[0]}, r);
		end
		$display("test range done");

		clear_st();
		for (int k = 0; k < 4; k++)
			wr(stsrq_pkg::stsrq_target_t'(k + 4), 1'b0, 3'd0,
				(k == 2) ? 8'h03 : 8'h00);
		wr(stsrq_pkg::TGT_SP_EN, 1'b1, 3'd3, 8'h01);
		auto_en = 1'b1;
		dly = 4'h3;
		n0 = polls;
		pulse(17'h0_0060);
		wait_polls(n0 + 1);
		check_byte("first_poll", 8'h48, last_poll & 8'h48);
		check_bit("srq_withdrawn", 1'b0, srq);
		pulse(17'h0_0020);
		repeat (10) @(negedge ref_clk_i);
		check_bit("one_request", 1'b1, polls == n0 + 1);
		auto_en = 1'b0;
		// One negedge sees the request, so the host polls exactly once
		@(posedge ref_clk_i);
		poll_req = 1'b1;
		@(posedge ref_clk_i);
		poll_req = 1'b0;
		wait_polls(n0 + 2);
		check_byte("later_poll", 8'h08, last_poll & 8'h48);
		query(stsrq_pkg::TGT_SPOLL, 1'b1, 3'd6, r);
		check_byte("query_srq", 8'h01, r);
		query(stsrq_pkg::TGT_MEAS, 1'b1, 3'd0, r);
		check_byte("bit_read", 8'h01, r);
		@(negedge ref_clk_i);
		query(stsrq_pkg::TGT_SPOLL, 1'b1, 3'd3, r);
		check_byte("summary_held", 8'h01, r);
		query(stsrq_pkg::TGT_MEAS, 1'b0, 3'd0, r);
		check_byte("source_read", 8'h02, r);
		@(negedge ref_clk_i);
		query(stsrq_pkg::TGT_SPOLL, 1'b1, 3'd3, r);
		check_byte("summary_gone", 8'h00, r);
		auto_en = 1'b1;
		pulse(17'h0_0020);
		wait_polls(n0 + 3);
		check_bit("new_request", 1'b1, polls == n0 + 3);
		auto_en = 1'b0;
		pulse(17'h0_0040);
		clear_st();
		query(stsrq_pkg::TGT_MEAS, 1'b0, 3'd0, r);
		check_byte("cleared_byte", 8'h00, r);
		query(stsrq_pkg::TGT_MEAS_EN, 1'b0, 3'd0, r);
		check_byte("mask_kept", 8'h03, r);
		$display("test service_request done");
		give_verdict();
	end
endmodule : status_reporting_srq_tb
